// ===== lcdcd_pkg.sv
// Constants, opcodes and carrier types for the LCD command decoder.
// Assumes a single 25 MHz core clock domain.
package lcdcd_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int INIT_RESET_NS = 100;
    // Longest time rounds down, never below one cycle
    localparam int INIT_CYC_RAW = INIT_RESET_NS / CLK_PERIOD_NS;
    localparam int INIT_CYCLES = (INIT_CYC_RAW < 1) ? 1 : INIT_CYC_RAW;
    localparam logic [2:0] INIT_CNT_LAST = 3'(INIT_CYCLES - 1);
    localparam int CAL_WORDS = 4;
    localparam logic [1:0] CAL_LAST = 2'(CAL_WORDS - 1);
    localparam int CAL_WIDTH = 8;
    localparam logic [7:0] FRAME_DIV_BASE = 8'h40;

    // ************************************************************
    // Opcodes
    // ************************************************************
    localparam logic [7:0] OP_INIT = 8'h3a;
    localparam logic [7:0] OP_CAL_REFRESH = 8'hd0;
    localparam logic [5:0] OP_OSC_CTRL = 6'h33;
    localparam logic [5:0] OP_PUMP_CTRL = 6'h30;
    localparam logic [5:0] OP_TEMP_CTRL = 6'h32;
    localparam logic [5:0] OP_BIAS = 6'h31;
    localparam logic [6:0] OP_DISP_EN = 7'h1c;
    localparam logic [6:0] OP_TEMP_FILT = 7'h69;
    localparam logic [5:0] OP_INV_MODE = 6'h35;
    localparam logic [4:0] OP_MUX = 5'h00;
    localparam logic [5:0] OP_BANK = 6'h02;
    localparam logic [1:0] OP_PTR = 2'h2;
    localparam logic [2:0] OP_FRAME = 3'h3;
    localparam logic [3:0] OP_VPR_HI = 4'h4;
    localparam logic [3:0] OP_VPR_LO = 4'h5;
    localparam logic [4:0] OP_SLA = 5'h03;
    localparam logic [4:0] OP_SLB = 5'h04;
    localparam logic [4:0] OP_SLC = 5'h05;
    localparam logic [4:0] OP_SLD = 5'h06;

    // ************************************************************
    // Configuration carrier and reset values
    // ************************************************************
    typedef struct packed {
        logic clock_output_enable;
        logic oscillator_source_select;
        logic pump_enable;
        logic pump_multiplier_select;
        logic temp_compensation_enable;
        logic temp_measure_enable;
        logic [2:0] slope_a;
        logic [2:0] slope_b;
        logic [2:0] slope_c;
        logic [2:0] slope_d;
        logic [7:0] voltage_target;
        logic display_enable;
        logic [2:0] mux_mode;
        logic [1:0] bias_mode;
        logic [5:0] data_pointer;
        logic [4:0] frame_rate;
        logic input_bank_choice;
        logic output_bank_choice;
        logic inversion_mode_bit;
        logic temperature_filter_enable;
    } lcdcd_cfg_t;

    localparam lcdcd_cfg_t CFG_RESET = '{
        temp_compensation_enable: 1'b1,
        temp_measure_enable: 1'b1,
        default: '0
    };

    typedef struct packed {
        logic valid;
        logic register_select;
        logic [7:0] data;
    } lcdcd_byte_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_INIT,
        ST_CAL
    } lcdcd_state_t;
endpackage : lcdcd_pkg

// ===== lcdcd_cal_mem.sv
// Small calibration store read one word per cycle.
// Assumes contents are fixed at build time; read data registered.
`timescale 1ns/1ps
`default_nettype none
module lcdcd_cal_mem
    import lcdcd_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic [1:0] addr_i,
    output logic [CAL_WIDTH-1:0] rdata_o
);
    // Factory trim values; arbitrary neutral contents
    function automatic logic [CAL_WIDTH-1:0] cal_word(input logic [1:0] a);
        case (a)
            2'h0: cal_word = 8'h80;
            2'h1: cal_word = 8'h40;
            2'h2: cal_word = 8'h20;
            default: cal_word = 8'h10;
        endcase
    endfunction : cal_word

    always_ff @(posedge core_clk_i) begin
        rdata_o <= cal_word(addr_i);
    end
endmodule : lcdcd_cal_mem
`default_nettype wire

// ===== lcdcd_decoder.sv
// Command decoder for a multiplexed LCD driver: opcode map, config, clock pin.
// Assumes bytes arrive already deframed on core_clk_i; clock pin is raw.
//
// What this block does
// [R1] Initialize byte resets every setting to default
// [R2] Initialize completes within 100 ns, no re-init
// [R3] Reload calibration at reset, initialize, refresh
// [R4] Host avoids power-down during calibration refresh
// [R5] Oscillator command: bit1 output, bit0 source
// [R6] Clock pin floats unless output enabled
// [R7] Source bit picks internal or external clock
// [R8] Clock output stays off after power-on
// [R9] Pump enable forces internal oscillator running
// [R10] Driven clock duty may be asymmetric
// [R11] Host keeps external clock running continuously
// [R12] Frame timing scales with selected clock
// [R13] Pump command: bit0 doubles or triples supply
// [R14] Pump bit1 enables internal voltage generation
// [R15] Select bit: zero command, one RAM data
// [R16] Host sends only defined opcodes
// [R17] Decode pointer load and frame-rate fields
// [R18] Route all other opcodes to config fields
`timescale 1ns/1ps
`default_nettype none
module lcdcd_decoder
    import lcdcd_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic byte_valid_i,
    input wire logic register_select_i,
    input wire logic [7:0] byte_data_i,
    input wire logic int_osc_clk_i,
    input wire logic clk_pin_i,
    output logic clk_pin_o,
    output logic clk_pin_oe_o,
    output logic int_osc_run_o,
    output logic frame_tick_o,
    output logic ram_we_o,
    output logic [5:0] ram_addr_o,
    output logic [7:0] ram_wdata_o,
    output logic cal_busy_o,
    output logic cal_load_o,
    output logic [1:0] cal_index_o,
    output logic [CAL_WIDTH-1:0] cal_data_o,
    output lcdcd_cfg_t cfg_o
);
    // ************************************************************
    // Input capture and pin synchronisers
    // ************************************************************
    lcdcd_byte_t in_byte;
    logic [1:0] int_sync;
    logic [1:0] ext_sync;
    logic sel_clk;
    logic sel_clk_d;
    lcdcd_state_t state;
    logic [2:0] init_cnt;
    logic [1:0] cal_addr;
    logic cal_rd_valid;
    logic [1:0] cal_rd_addr;
    logic [CAL_WIDTH-1:0] cal_rdata;
    logic [7:0] frame_cnt;
    logic is_cmd;
    logic init_hit;
    logic refresh_hit;

    assign in_byte = '{valid: byte_valid_i, register_select: register_select_i,
                       data: byte_data_i};
    assign is_cmd = in_byte.valid && !in_byte.register_select; // R15
    assign init_hit = is_cmd && (in_byte.data == OP_INIT) && (state != ST_INIT);
    assign refresh_hit = is_cmd && (in_byte.data == OP_CAL_REFRESH);

    always_ff @(posedge core_clk_i) begin
        int_sync <= {int_sync[0], int_osc_clk_i};
        ext_sync <= {ext_sync[0], clk_pin_i};
    end

    // ************************************************************
    // Sequencer: initialize reset, then calibration reload
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state <= ST_CAL; // R3
            init_cnt <= '0;
            cal_addr <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (init_hit) begin
                        state <= ST_INIT; // R1
                        init_cnt <= '0;
                    end else if (refresh_hit) begin
                        state <= ST_CAL; // R3
                        cal_addr <= '0;
                    end
                end
                ST_INIT: begin
                    if (init_cnt == INIT_CNT_LAST) begin
                        state <= ST_CAL; // R2 R3
                        cal_addr <= '0;
                    end else begin
                        init_cnt <= init_cnt + 3'h1;
                    end
                end
                default: begin
                    // An initialize must still win over a running reload
                    if (init_hit) begin
                        state <= ST_INIT; // R1
                        init_cnt <= '0;
                    end else if (cal_addr == CAL_LAST) begin
                        state <= ST_IDLE;
                    end else begin
                        cal_addr <= cal_addr + 2'h1;
                    end
                end
            endcase
        end
    end

    lcdcd_cal_mem u_cal_mem (
        .core_clk_i(core_clk_i),
        .addr_i(cal_addr),
        .rdata_o(cal_rdata)
    );

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cal_rd_valid <= 1'b0;
            cal_rd_addr <= '0;
            cal_load_o <= 1'b0;
            cal_index_o <= '0;
            cal_data_o <= '0;
            cal_busy_o <= 1'b1;
        end else begin
            cal_rd_valid <= (state == ST_CAL);
            cal_rd_addr <= cal_addr;
            cal_load_o <= cal_rd_valid;
            cal_index_o <= cal_rd_addr;
            cal_data_o <= cal_rdata;
            // Busy covers the read pipeline so the host can wait on it
            cal_busy_o <= (state != ST_IDLE) || cal_rd_valid; // R4
        end
    end

    // ************************************************************
    // Opcode decode into configuration
    // ************************************************************
    // Bytes arriving during the short init pulse are dropped; host must
    // not stream commands within 100 ns of an initialize.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || (state == ST_INIT)) begin
            cfg_o <= CFG_RESET; // R1 R8
        end else if (is_cmd) begin
            if (in_byte.data[7:2] == OP_OSC_CTRL) begin
                cfg_o.clock_output_enable <= in_byte.data[1]; // R5
                cfg_o.oscillator_source_select <= in_byte.data[0]; // R5
            end else if (in_byte.data[7:2] == OP_PUMP_CTRL) begin
                cfg_o.pump_enable <= in_byte.data[1]; // R14
                cfg_o.pump_multiplier_select <= in_byte.data[0]; // R13
            end else if (in_byte.data[7:2] == OP_TEMP_CTRL) begin
                cfg_o.temp_compensation_enable <= in_byte.data[1]; // R18
                cfg_o.temp_measure_enable <= in_byte.data[0];
            end else if (in_byte.data[7:2] == OP_BIAS) begin
                cfg_o.bias_mode <= in_byte.data[1:0]; // R18
            end else if (in_byte.data[7:1] == OP_TEMP_FILT) begin
                cfg_o.temperature_filter_enable <= in_byte.data[0]; // R18
            end else if (in_byte.data[7:2] == OP_INV_MODE) begin
                cfg_o.inversion_mode_bit <= in_byte.data[1]; // R18
            end else if (in_byte.data[7:1] == OP_DISP_EN) begin
                cfg_o.display_enable <= in_byte.data[0]; // R18
            end else if (in_byte.data[7:6] == OP_PTR) begin
                cfg_o.data_pointer <= in_byte.data[5:0]; // R17
            end else if (in_byte.data[7:5] == OP_FRAME) begin
                cfg_o.frame_rate <= in_byte.data[4:0]; // R17
            end else if (in_byte.data[7:4] == OP_VPR_HI) begin
                cfg_o.voltage_target[7:4] <= in_byte.data[3:0]; // R18
            end else if (in_byte.data[7:4] == OP_VPR_LO) begin
                cfg_o.voltage_target[3:0] <= in_byte.data[3:0];
            end else if (in_byte.data[7:3] == OP_SLA) begin
                cfg_o.slope_a <= in_byte.data[2:0]; // R18
            end else if (in_byte.data[7:3] == OP_SLB) begin
                cfg_o.slope_b <= in_byte.data[2:0];
            end else if (in_byte.data[7:3] == OP_SLC) begin
                cfg_o.slope_c <= in_byte.data[2:0];
            end else if (in_byte.data[7:3] == OP_SLD) begin
                cfg_o.slope_d <= in_byte.data[2:0];
            end else if (in_byte.data[7:3] == OP_MUX) begin
                cfg_o.mux_mode <= in_byte.data[2:0]; // R18
            end else if (in_byte.data[7:2] == OP_BANK) begin
                cfg_o.input_bank_choice <= in_byte.data[1]; // R18
                cfg_o.output_bank_choice <= in_byte.data[0];
            end
        end else if (ram_we_o) begin
            // Pointer advances after each stored data byte unless a command byte follows in the next cycle
            cfg_o.data_pointer <= cfg_o.data_pointer + 6'h01;
        end
    end

    // ************************************************************
    // Display RAM write path
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ram_we_o <= 1'b0;
            ram_addr_o <= '0;
            ram_wdata_o <= '0;
        end else begin
            ram_we_o <= in_byte.valid && in_byte.register_select
                        && (state != ST_INIT); // R15
            ram_addr_o <= cfg_o.data_pointer;
            ram_wdata_o <= in_byte.data;
        end
    end

    // ************************************************************
    // Clock selection, pin drive and frame timing
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sel_clk <= 1'b0;
            sel_clk_d <= 1'b0;
            clk_pin_o <= 1'b0;
            clk_pin_oe_o <= 1'b0;
            int_osc_run_o <= 1'b1;
            frame_cnt <= '0;
            frame_tick_o <= 1'b0;
        end else begin
            sel_clk <= cfg_o.oscillator_source_select ? ext_sync[1] : int_sync[1]; // R7
            sel_clk_d <= sel_clk;
            // Pin only drives the internal clock; duty follows the osc as is
            clk_pin_o <= int_sync[1]; // R10
            clk_pin_oe_o <= cfg_o.clock_output_enable
                            && !cfg_o.oscillator_source_select; // R6 R8
            int_osc_run_o <= !cfg_o.oscillator_source_select
                             || cfg_o.pump_enable; // R9
            frame_tick_o <= 1'b0;
            if (sel_clk && !sel_clk_d) begin
                // Fixed edge count: frame rate tracks the clock rate
                if (frame_cnt >= FRAME_DIV_BASE + {3'h0, cfg_o.frame_rate}) begin
                    frame_cnt <= '0;
                    frame_tick_o <= 1'b1; // R12
                end else begin
                    frame_cnt <= frame_cnt + 8'h01;
                end
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_init_resets_cfg: assert property ( // R1
        is_cmd && in_byte.data == OP_INIT && state == ST_IDLE |=> ##1 cfg_o == CFG_RESET)
        else $error("init did not restore defaults");
    a_init_short: assert property ( // R2
        state == ST_INIT |-> ##[1:3] state != ST_INIT)
        else $error("init lasted too long");
    a_refresh_reload: assert property ( // R3
        state == ST_IDLE && refresh_hit && !init_hit |=> state == ST_CAL ##2 cal_load_o)
        else $error("refresh did not reload");
    a_osc_bits: assert property ( // R5
        is_cmd && in_byte.data[7:2] == OP_OSC_CTRL && state != ST_INIT
        |=> cfg_o.clock_output_enable == $past(in_byte.data[1])
            && cfg_o.oscillator_source_select == $past(in_byte.data[0]))
        else $error("oscillator bits not captured");
    a_pin_float: assert property ( // R6
        !cfg_o.clock_output_enable |=> !clk_pin_oe_o)
        else $error("clock pin driven while disabled");
    a_pump_osc: assert property ( // R9
        cfg_o.pump_enable |=> int_osc_run_o)
        else $error("pump on without oscillator");
    a_pump_bits: assert property ( // R13
        is_cmd && in_byte.data[7:2] == OP_PUMP_CTRL && state != ST_INIT
        |=> cfg_o.pump_enable == $past(in_byte.data[1])
            && cfg_o.pump_multiplier_select == $past(in_byte.data[0]))
        else $error("pump bits not captured");
    a_ram_write: assert property ( // R15
        in_byte.valid && in_byte.register_select && state != ST_INIT
        |=> ram_we_o && ram_wdata_o == $past(in_byte.data))
        else $error("data byte not stored");
    a_frame_field: assert property ( // R17
        is_cmd && in_byte.data[7:5] == OP_FRAME && state != ST_INIT
        |=> cfg_o.frame_rate == $past(in_byte.data[4:0]))
        else $error("frame field not captured");

    c_init: cover property (state == ST_INIT ##[1:8] state == ST_IDLE);
    c_ext_clk: cover property (cfg_o.oscillator_source_select && frame_tick_o);
    c_pin_out: cover property (clk_pin_oe_o);
    c_ram: cover property (ram_we_o ##1 ram_we_o);
endmodule : lcdcd_decoder
`default_nettype wire

// ===== lcdcd_host_model.sv
// Host-side partner: sends tagged bytes, supplies both oscillator levels.
// Assumes the bench calls send() and resolves the clock pin level itself.
`timescale 1ns/1ps
`default_nettype none
module lcdcd_host_model (
    input wire logic core_clk_i,
    input wire logic ext_run_i,
    output logic byte_valid_o,
    output logic register_select_o,
    output logic [7:0] byte_data_o,
    output logic int_osc_o,
    output logic ext_clk_o
);
    // ************************************************************
    // Byte transfer
    // ************************************************************
    logic [1:0] osc_cnt;
    logic [1:0] ext_cnt;

    initial begin
        byte_valid_o = 1'b0;
        register_select_o = 1'b0;
        byte_data_o = 8'h00;
        int_osc_o = 1'b0;
        ext_clk_o = 1'b0;
        osc_cnt = 2'h0;
        ext_cnt = 2'h0;
    end

    // One-cycle byte; lines show the inverse once released
    task automatic send(input logic rs, input logic [7:0] d);
        @(posedge core_clk_i);
        byte_valid_o <= 1'b1;
        register_select_o <= rs;
        byte_data_o <= d;
        @(posedge core_clk_i);
        byte_valid_o <= 1'b0;
        register_select_o <= ~rs;
        byte_data_o <= ~d;
    endtask : send

    // ************************************************************
    // Oscillators
    // ************************************************************
    // Internal osc: half period 2 cycles
    always @(posedge core_clk_i) begin
        osc_cnt <= osc_cnt + 2'h1;
        if (osc_cnt == 2'h1) begin
            osc_cnt <= 2'h0;
            int_osc_o <= ~int_osc_o;
        end
    end

    // External clock never stops while enabled; idle pin toggles each cycle
    always @(posedge core_clk_i) begin
        ext_cnt <= ext_cnt + 2'h1;
        if (!ext_run_i) begin
            ext_clk_o <= ~ext_clk_o;
        end else if (ext_cnt >= 2'h2) begin
            ext_cnt <= 2'h0;
            ext_clk_o <= ~ext_clk_o;
        end
    end
endmodule : lcdcd_host_model
`default_nettype wire

// ===== lcd_driver_command_decoder_bench.sv
// Self-checking bench for the LCD command decoder.
// Assumes the host model drives all byte and oscillator inputs.
`timescale 1ns/1ps
`default_nettype none
module lcd_driver_command_decoder_bench
    import lcdcd_pkg::*;
;
    // ************************************************************
    // Clock, reset, wiring
    // ************************************************************
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ext_run = 1'b0;
    logic bv, rs, osc, ext, pin_o, pin_oe, osc_run, tick, we, busy, cl;
    logic [7:0] bd, wdata, cdata;
    logic [5:0] waddr;
    logic [1:0] cidx;
    logic pin_level;
    lcdcd_cfg_t cfg, e;
    int n_errors = 0;
    int samples_checked = 0;
    int cal_cnt = 0;
    int we_cnt = 0;
    int cal_total = 0;
    logic [7:0] cal_ref [4];
    logic [5:0] w_addr [2];
    logic [7:0] w_data [2];
    logic [7:0] tbl [12] = '{8'hc8, 8'h1b, 8'h25, 8'h2e, 8'h37, 8'h4a,
                             8'h55, 8'h39, 8'h04, 8'hc5, 8'h0b, 8'hd6};

    always #20 core_clk = ~core_clk;
    // Pin is driven by the device only while its enable is high
    assign pin_level = pin_oe ? pin_o : ext;

    lcdcd_host_model host (.core_clk_i(core_clk), .ext_run_i(ext_run),
        .byte_valid_o(bv), .register_select_o(rs), .byte_data_o(bd),
        .int_osc_o(osc), .ext_clk_o(ext));

    lcdcd_decoder uut (.core_clk_i(core_clk), .sys_rst_i(sys_rst), .byte_valid_i(bv),
        .register_select_i(rs), .byte_data_i(bd), .int_osc_clk_i(osc),
        .clk_pin_i(pin_level), .clk_pin_o(pin_o), .clk_pin_oe_o(pin_oe),
        .int_osc_run_o(osc_run), .frame_tick_o(tick), .ram_we_o(we),
        .ram_addr_o(waddr), .ram_wdata_o(wdata), .cal_busy_o(busy),
        .cal_load_o(cl), .cal_index_o(cidx), .cal_data_o(cdata), .cfg_o(cfg));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
        samples_checked++;
        if (got !== ex) begin
            n_errors++;
            $display("[ERR] %s exp=%h got=%h", nm, ex, got);
        end
    endtask : chk

    task automatic put(input logic r, input logic [7:0] d);
        host.send(r, d);
        repeat (2) @(posedge core_clk);
        #1;
    endtask : put

    task automatic wait_cal();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 40) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= 40) begin
            chk("cal_busy_timeout", 0, 1);
            close_out();
        end
    endtask : wait_cal

    task automatic tick_wait(output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (tick !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            chk("frame_tick_timeout", 0, 1);
            close_out();
        end
    endtask : tick_wait

    task automatic period(input int ex);
        int n;
        tick_wait(n);
        tick_wait(n);
        tick_wait(n);
        chk("frame_period", ex, n);
    endtask : period

    // Watch the one-cycle pulses; index must count up from 0
    always @(posedge core_clk) begin
        if (cl === 1'b1) begin
            chk("cal_index", cal_cnt % 4, cidx);
            // Every later reload must bring back the power-on words
            if (cal_total < 4) begin
                cal_ref[cal_total] = cdata;
            end else begin
                chk("cal_data", cal_ref[cal_total % 4], cdata);
            end
            cal_cnt = cal_cnt + 1;
            cal_total = cal_total + 1;
        end
        if (we === 1'b1) begin
            if (we_cnt < 2) begin
                w_addr[we_cnt] = waddr;
                w_data[we_cnt] = wdata;
            end
            we_cnt = we_cnt + 1;
        end
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        int r;
        logic prv;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("cfg_reset", CFG_RESET, cfg);
        chk("pin_oe_reset", 0, pin_oe);
        chk("busy_reset", 1, busy);
        wait_cal();
        chk("cal_words", 4, cal_cnt);
        $display("test reset done");

        put(1'b0, 8'hce);
        chk("coe", 1, cfg.clock_output_enable);
        chk("osc_src", 0, cfg.oscillator_source_select);
        chk("pin_oe_on", 1, pin_oe);
        r = 0;
        prv = pin_o;
        repeat (64) begin
            @(posedge core_clk);
            #1;
            if (pin_o === 1'b1 && prv === 1'b0) r++;
            prv = pin_o;
        end
        chk("pin_rises", 1, (r >= 15 && r <= 17));
        $display("test osc done");

        put(1'b0, 8'h6a);
        chk("frame_rate", 10, cfg.frame_rate);
        period((64 + 10 + 1) * 4);
        ext_run <= 1'b1;
        put(1'b0, 8'hcd);
        chk("pin_oe_ext", 0, pin_oe);
        chk("osc_run_ext", 0, osc_run);
        period((64 + 10 + 1) * 6);
        put(1'b0, 8'hc3);
        chk("pump_en", 1, cfg.pump_enable);
        chk("pump_x3", 1, cfg.pump_multiplier_select);
        chk("osc_run_pump", 1, osc_run);
        $display("test clock done");

        put(1'b0, 8'h85);
        chk("pointer", 5, cfg.data_pointer);
        put(1'b1, 8'ha5);
        put(1'b1, 8'h3a);
        chk("ram_writes", 2, we_cnt);
        chk("ram_addr0", 5, w_addr[0]);
        chk("ram_addr1", 6, w_addr[1]);
        chk("ram_data0", 8'ha5, w_data[0]);
        chk("ram_data1", 8'h3a, w_data[1]);
        chk("no_init_on_data", 1, cfg.pump_enable);
        $display("test data done");

        e = cfg;
        foreach (tbl[i]) put(1'b0, tbl[i]);
        e.temp_compensation_enable = 1'b0;
        e.temp_measure_enable = 1'b0;
        e.slope_a = 3'h3;
        e.slope_b = 3'h5;
        e.slope_c = 3'h6;
        e.slope_d = 3'h7;
        e.voltage_target = 8'ha5;
        e.display_enable = 1'b1;
        e.mux_mode = 3'h4;
        e.bias_mode = 2'h1;
        e.input_bank_choice = 1'b1;
        e.output_bank_choice = 1'b1;
        e.inversion_mode_bit = 1'b1;
        chk("cfg_routes", e, cfg);
        $display("test routes done");

        cal_cnt = 0;
        put(1'b0, 8'h3a);
        chk("init_cfg", CFG_RESET, cfg);
        chk("init_pin_oe", 0, pin_oe);
        wait_cal();
        chk("init_cal", 4, cal_cnt);
        put(1'b0, 8'hce);
        chk("after_init", 1, cfg.clock_output_enable);
        cal_cnt = 0;
        put(1'b0, 8'hd0);
        wait_cal();
        chk("refresh_cal", 4, cal_cnt);
        chk("refresh_keeps", 1, cfg.clock_output_enable);
        $display("test init done");
        close_out();
    end
endmodule : lcd_driver_command_decoder_bench
`default_nettype wire
